//--- rtl/efs_pkg.sv
// Constants for the encoder feedback and status block.
// Assumes a register port at word offsets and a single 20 MHz system clock.
package efs_pkg;

    // ==========================================================
    // Register offsets (word index on the register port)
    localparam logic [7:0] ADDR_MOTION_FLAGS   = 8'h0B; // Ramp and deviation flags
    localparam logic [7:0] ADDR_STEP_SCALE     = 8'h0D; // Step input scale
    localparam logic [7:0] ADDR_ENC_INCREMENT  = 8'h10; // Encoder increment 16.16
    localparam logic [7:0] ADDR_ENC_POSITION   = 8'h11; // Encoder position
    localparam logic [7:0] ADDR_ENC_CONFIG     = 8'h12; // Encoder configuration
    localparam logic [7:0] ADDR_INDEX_FLAG     = 8'h13; // Index event flag, read clears
    localparam logic [7:0] ADDR_INDEX_CAPTURE  = 8'h14; // Position caught on index
    localparam logic [7:0] ADDR_SWITCH_CAPTURE = 8'h15; // Ramp position caught on switch
    localparam logic [7:0] ADDR_DEV_THRESHOLD  = 8'h16; // Deviation warning threshold

    // ==========================================================
    // Widths and reset values
    localparam int unsigned FLAGS_W  = 5;
    localparam int unsigned SCALE_W  = 16;
    localparam int unsigned CONFIG_W = 14;
    localparam int unsigned THRESH_W = 20;
    localparam logic [31:0] ENC_INCREMENT_RESET = 32'h0001_0000; // 1.0

    // ==========================================================
    // Field positions
    localparam int unsigned FLAG_POS_REACHED = 0;
    localparam int unsigned FLAG_V_REACHED   = 1;
    localparam int unsigned FLAG_STANDSTILL  = 2;
    localparam int unsigned FLAG_DEVIATION   = 4;
    localparam int unsigned STEP_POLARITY    = 15;
    localparam int unsigned CFG_POL_A        = 0;
    localparam int unsigned CFG_POL_B        = 1;
    localparam int unsigned CFG_POL_N        = 2;
    localparam int unsigned CFG_IGNORE_AB    = 3;
    localparam int unsigned CFG_POS_EDGE     = 6;
    localparam int unsigned CFG_NEG_EDGE     = 7;
    localparam int unsigned CFG_CLEAR_POS    = 8;
    localparam int unsigned CFG_DECIMAL      = 13;

    // ==========================================================
    // Fraction moduli
    localparam logic [16:0] FRAC_MOD_BINARY  = 17'h1_0000; // Parts of 65536
    localparam logic [16:0] FRAC_MOD_DECIMAL = 17'h0_2710; // Parts of 10000

    // ==========================================================
    // Pin order inside the synchroniser vector
    localparam int unsigned PIN_A     = 0;
    localparam int unsigned PIN_B     = 1;
    localparam int unsigned PIN_N     = 2;
    localparam int unsigned PIN_STEP  = 3;
    localparam int unsigned PIN_DIR   = 4;
    localparam int unsigned PIN_COUNT = 5;

endpackage

//--- rtl/encoder_feedback_status.sv
// Encoder feedback, position capture, step input scaling and motion flags.
// Assumes ramp values arrive from logic on clock_in; encoder and step pins are asynchronous.
module encoder_feedback_status #(
    parameter int unsigned THRESH_W = efs_pkg::THRESH_W  // Deviation threshold width
) (
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    // Register port
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire logic [31:0]         reg_wdata_in,
    output logic      [31:0]         reg_rdata_out,
    // Encoder and step pins
    input  wire logic                enc_a_in,
    input  wire logic                enc_b_in,
    input  wire logic                enc_n_in,
    input  wire logic                step_in,
    input  wire logic                dir_in,
    // Ramp generator and mode values
    input  wire logic [31:0]         x_actual_in,
    input  wire logic [31:0]         x_target_in,
    input  wire logic [31:0]         v_actual_in,
    input  wire logic [31:0]         v_target_in,
    input  wire logic [31:0]         v_max_in,
    input  wire logic                positioning_in,
    input  wire logic                soft_limit_stop_in,
    input  wire logic                ref_switch_event_in,
    input  wire logic                virtual_stop_event_in,
    input  wire logic                step_enable_in,
    input  wire logic                feedback_enable_in,
    // Results
    output logic                     goal_step_out,
    output logic                     goal_down_out,
    output logic [efs_pkg::FLAGS_W-1:0] motion_flags_out,
    output logic                     deviation_irq_out
);

    // ==========================================================
    // State record
    typedef struct packed {
        logic [efs_pkg::PIN_COUNT-1:0] pin_s1;     // First sync stage
        logic [efs_pkg::PIN_COUNT-1:0] pin_s2;     // Second sync stage
        logic [1:0]                    ab_prev;    // Last A/B pair
        logic                          n_prev;     // Last active index level
        logic                          lvl_prev;   // Last qualified index level
        logic                          step_prev;  // Last step level
        logic [efs_pkg::SCALE_W-1:0]   scale;      // Step input scale
        logic [31:0]                   increment;  // Encoder increment 16.16
        logic [31:0]                   enc_pos;    // Encoder position
        logic [15:0]                   enc_frac;   // Hidden position fraction
        logic [efs_pkg::CONFIG_W-1:0]  config_w;   // Encoder configuration
        logic                          idx_flag;   // Index event flag
        logic [31:0]                   idx_cap;    // Index capture
        logic [31:0]                   sw_cap;     // Switch capture
        logic [THRESH_W-1:0]           thresh;     // Deviation threshold
        logic [31:0]                   loop_err;   // Ramp minus encoder
        logic [efs_pkg::FLAGS_W-1:0]   flags;      // Motion flags
        logic [14:0]                   step_frac;  // Goal fraction of a microstep
        logic                          goal_step;  // Goal moves one microstep
        logic                          goal_down;  // Direction of that move
        logic                          irq;        // Deviation interrupt pulse
        logic [31:0]                   rdata;      // Read data
    } state_type;

    state_type st_r;   // Registered state
    state_type st_nxt; // Next state

    // Combinational helpers
    logic        cnt_evt;   // One quadrature count
    logic        cnt_up;    // Count direction
    logic        n_act;     // Index pin at active level
    logic        lvl_now;   // Index qualified by A/B
    logic        idx_evt;   // Index event this cycle
    logic        step_rise; // Accepted step pulse
    logic        step_up;   // Step moves goal upward
    logic        pos_write; // Host writes encoder position
    logic [16:0] frac_mod;  // Active fraction modulus
    logic [16:0] frac_sum;  // Fraction plus increment
    logic [16:0] frac_dif;  // Fraction minus increment
    logic        frac_cy;   // Carry or borrow to integer
    logic [31:0] int_step;  // Integer part plus carry
    logic [15:0] step_amt;  // Weight plus one
    logic [15:0] step_sum;  // Step fraction working value
    logic [32:0] abs_err;   // Absolute loop error
    logic        dev_over;  // Deviation beyond threshold

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_nxt    = st_r;
        st_nxt.pin_s1 = {dir_in, step_in, enc_n_in, enc_b_in, enc_a_in};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.ab_prev = {st_r.pin_s2[efs_pkg::PIN_A], st_r.pin_s2[efs_pkg::PIN_B]};
        pos_write = reg_wr_in && (reg_addr_in == efs_pkg::ADDR_ENC_POSITION);

        // Quadrature: one bit changed is one count; both changed is dropped as noise
        cnt_evt = ^(st_r.ab_prev ^ st_nxt.ab_prev);
        cnt_up  = ~(st_r.ab_prev[1] ^ st_nxt.ab_prev[0]);

        // Fraction arithmetic in binary or decimal parts
        frac_mod = st_r.config_w[efs_pkg::CFG_DECIMAL] ? efs_pkg::FRAC_MOD_DECIMAL
                                                       : efs_pkg::FRAC_MOD_BINARY;
        frac_sum = {1'b0, st_r.enc_frac} + {1'b0, st_r.increment[15:0]};
        frac_dif = {1'b0, st_r.enc_frac} - {1'b0, st_r.increment[15:0]};
        frac_cy  = cnt_up ? (frac_sum >= frac_mod) : frac_dif[16];
        int_step = {{16{st_r.increment[31]}}, st_r.increment[31:16]} + {31'b0, frac_cy};

        // Index detection, edge or qualified level
        n_act   = st_r.pin_s2[efs_pkg::PIN_N] == st_r.config_w[efs_pkg::CFG_POL_N];
        lvl_now = n_act && (st_r.config_w[efs_pkg::CFG_IGNORE_AB] ||
                  ((st_r.pin_s2[efs_pkg::PIN_A] == st_r.config_w[efs_pkg::CFG_POL_A]) &&
                   (st_r.pin_s2[efs_pkg::PIN_B] == st_r.config_w[efs_pkg::CFG_POL_B])));
        if (st_r.config_w[efs_pkg::CFG_POS_EDGE] || st_r.config_w[efs_pkg::CFG_NEG_EDGE]) begin
            idx_evt = (st_r.config_w[efs_pkg::CFG_POS_EDGE] && n_act && !st_r.n_prev) ||
                      (st_r.config_w[efs_pkg::CFG_NEG_EDGE] && !n_act && st_r.n_prev);
        end else begin
            idx_evt = lvl_now && !st_r.lvl_prev;
        end
        st_nxt.n_prev   = n_act;
        st_nxt.lvl_prev = lvl_now;

        // Encoder position: host write beats index clear beats count
        if (cnt_evt) begin
            if (cnt_up) begin
                st_nxt.enc_pos  = st_r.enc_pos + int_step;
                st_nxt.enc_frac = frac_cy ? 16'(frac_sum - frac_mod) : frac_sum[15:0];
            end else begin
                st_nxt.enc_pos  = st_r.enc_pos - int_step;
                st_nxt.enc_frac = frac_cy ? 16'(frac_dif + frac_mod) : frac_dif[15:0];
            end
        end
        if (idx_evt) begin
            st_nxt.idx_cap = st_r.enc_pos;
            if (st_r.config_w[efs_pkg::CFG_CLEAR_POS]) begin
                st_nxt.enc_pos  = 32'h0000_0000;
                st_nxt.enc_frac = 16'h0000;
            end
        end

        // Switch capture of ramp position
        if (ref_switch_event_in || virtual_stop_event_in) begin
            st_nxt.sw_cap = x_actual_in;
        end

        // Step input scaling; at most one microstep per pulse
        step_rise = step_enable_in && st_r.pin_s2[efs_pkg::PIN_STEP] && !st_r.step_prev;
        step_up   = st_r.pin_s2[efs_pkg::PIN_DIR] ^ st_r.scale[efs_pkg::STEP_POLARITY];
        step_amt  = {1'b0, st_r.scale[14:0]} + 16'h0001;
        step_sum  = step_up ? ({1'b0, st_r.step_frac} + step_amt)
                            : ({1'b0, st_r.step_frac} - step_amt);
        st_nxt.step_prev = st_r.pin_s2[efs_pkg::PIN_STEP];
        st_nxt.goal_step = 1'b0;
        st_nxt.goal_down = st_r.goal_down;
        if (step_rise) begin
            st_nxt.step_frac = step_sum[14:0];
            st_nxt.goal_step = step_sum[15];
            st_nxt.goal_down = !step_up;
        end

        // Loop error frozen while the feedback loop is off
        if (feedback_enable_in) begin
            st_nxt.loop_err = x_actual_in - st_r.enc_pos;
        end
        abs_err  = st_r.loop_err[31] ? (33'h0_0000_0000 - {1'b1, st_r.loop_err})
                                     : {1'b0, st_r.loop_err};
        dev_over = abs_err > {{(33-THRESH_W){1'b0}}, st_r.thresh};

        // Motion flags
        st_nxt.flags = '0;
        st_nxt.flags[efs_pkg::FLAG_STANDSTILL] = (v_actual_in == 32'h0000_0000);
        st_nxt.flags[efs_pkg::FLAG_POS_REACHED] = (v_actual_in == 32'h0000_0000) &&
            ((x_actual_in == x_target_in) || soft_limit_stop_in);
        st_nxt.flags[efs_pkg::FLAG_V_REACHED] = (v_actual_in == v_target_in) ||
            (positioning_in && (v_actual_in == v_max_in));
        st_nxt.flags[efs_pkg::FLAG_DEVIATION] = dev_over;
        st_nxt.irq = dev_over && !st_r.flags[efs_pkg::FLAG_DEVIATION];

        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                efs_pkg::ADDR_STEP_SCALE:    st_nxt.scale = reg_wdata_in[efs_pkg::SCALE_W-1:0];
                efs_pkg::ADDR_ENC_INCREMENT: st_nxt.increment = reg_wdata_in;
                efs_pkg::ADDR_ENC_POSITION: begin
                    st_nxt.enc_pos  = reg_wdata_in;
                    st_nxt.enc_frac = 16'h0000;
                end
                efs_pkg::ADDR_ENC_CONFIG:    st_nxt.config_w = reg_wdata_in[efs_pkg::CONFIG_W-1:0];
                efs_pkg::ADDR_DEV_THRESHOLD: st_nxt.thresh = reg_wdata_in[THRESH_W-1:0];
                default: ;
            endcase
        end

        // Register reads; write-only and unmapped offsets read zero
        st_nxt.rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                efs_pkg::ADDR_MOTION_FLAGS:   st_nxt.rdata = {27'h0, st_r.flags};
                efs_pkg::ADDR_ENC_POSITION:   st_nxt.rdata = st_r.enc_pos;
                efs_pkg::ADDR_INDEX_FLAG:     st_nxt.rdata = {31'h0, st_r.idx_flag};
                efs_pkg::ADDR_INDEX_CAPTURE:  st_nxt.rdata = st_r.idx_cap;
                efs_pkg::ADDR_SWITCH_CAPTURE: st_nxt.rdata = st_r.sw_cap;
                default:                      st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Index flag: a new event wins over the read that clears it
        if (reg_rd_in && (reg_addr_in == efs_pkg::ADDR_INDEX_FLAG)) begin
            st_nxt.idx_flag = 1'b0;
        end
        if (idx_evt) begin
            st_nxt.idx_flag = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r           <= '0;
            st_r.increment <= efs_pkg::ENC_INCREMENT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out     = st_r.rdata;
    assign goal_step_out     = st_r.goal_step;
    assign goal_down_out     = st_r.goal_down;
    assign motion_flags_out  = st_r.flags;
    assign deviation_irq_out = st_r.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    AST_POS_REACHED_AT_REST: assert property (
        motion_flags_out[efs_pkg::FLAG_POS_REACHED] |-> $past(v_actual_in) == 32'h0000_0000)
        else $error("position reached flag while moving");
    AST_STANDSTILL: assert property (
        (v_actual_in == 32'h0000_0000) |=> motion_flags_out[efs_pkg::FLAG_STANDSTILL])
        else $error("standstill flag missing");
    AST_DEVIATION_FLAG: assert property (
        dev_over |=> motion_flags_out[efs_pkg::FLAG_DEVIATION])
        else $error("deviation flag missing");
    AST_FULL_WEIGHT_STEP: assert property (
        (step_rise && st_r.scale[14:0] == 15'h7FFF) |=> goal_step_out)
        else $error("full weight step did not move goal");
    AST_STEP_DISABLED: assert property (
        !step_enable_in |=> !goal_step_out)
        else $error("goal moved while step input disabled");
    AST_UNIT_COUNT: assert property (
        (cnt_evt && cnt_up && st_r.increment == efs_pkg::ENC_INCREMENT_RESET
         && !idx_evt && !pos_write) |=> st_r.enc_pos == $past(st_r.enc_pos) + 32'h1)
        else $error("unit increment count wrong");
    AST_INDEX_FLAG: assert property (
        idx_evt |=> st_r.idx_flag)
        else $error("index flag not set");
    AST_INDEX_CAPTURE: assert property (
        idx_evt |=> st_r.idx_cap == $past(st_r.enc_pos))
        else $error("index capture wrong");
    AST_SWITCH_CAPTURE: assert property (
        (ref_switch_event_in || virtual_stop_event_in) |=> st_r.sw_cap == $past(x_actual_in))
        else $error("switch capture wrong");
    AST_INDEX_CLEAR: assert property (
        (idx_evt && st_r.config_w[efs_pkg::CFG_CLEAR_POS] && !pos_write)
        |=> st_r.enc_pos == 32'h0000_0000)
        else $error("position not cleared on index");
    AST_IRQ_WITH_FLAG: assert property (
        deviation_irq_out |-> motion_flags_out[efs_pkg::FLAG_DEVIATION] ##1 !deviation_irq_out)
        else $error("interrupt without deviation flag");

    COV_INDEX: cover property (idx_evt ##1 st_r.idx_flag);
    COV_GOAL_STEP: cover property (step_rise ##1 goal_step_out);
    COV_IRQ: cover property (deviation_irq_out);
    COV_FLAG_READ: cover property (st_r.idx_flag && reg_rd_in
                                   && reg_addr_in == efs_pkg::ADDR_INDEX_FLAG);

endmodule // encoder_feedback_status

//--- tb/quad_encoder_model.sv
// Behavioural quadrature encoder with an index channel.
// Assumes the bench calls its tasks; pins change 2 ns after a clock edge.
module quad_encoder_model (
    // Clock
    input  wire logic clock_in,
    // Encoder pins
    output logic      enc_a_out,
    output logic      enc_b_out,
    output logic      enc_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Shaft phase; gray coded so only one pin changes per count
    logic [1:0] phase = 2'h0;
    initial enc_n_out = 1'b0;
    assign enc_a_out = phase[1] ^ phase[0]; // A leads B when turning up
    assign enc_b_out = phase[1];
    // Turn by n counts; gap sets the speed, prompt or slow
    task automatic turn(input int n, input bit up, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge clock_in);
            #2;
            phase = up ? phase + 2'h1 : phase - 2'h1;
        end
    endtask
    // Index pulse of a given width, idle low between pulses
    task automatic pulse_index(input int width);
        @(posedge clock_in);
        #2;
        enc_n_out = 1'b1;
        repeat (width) @(posedge clock_in);
        #2;
        enc_n_out = 1'b0;
    endtask
endmodule // quad_encoder_model

//--- tb/encoder_feedback_status_bench.sv
// Self-checking bench for the encoder feedback and status block.
// Assumes the package constants; reads are checked from a queue of notes.
module encoder_feedback_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stimulus and observation
    logic        clock_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, x_actual_in = 32'h0, x_target_in = 32'h0;
    logic [31:0] v_actual_in = 32'h0, v_target_in = 32'h0, v_max_in = 32'h0, r;
    logic        positioning_in = 1'b0, soft_limit_stop_in = 1'b0, ref_switch_event_in = 1'b0;
    logic        virtual_stop_event_in = 1'b0, step_enable_in = 1'b0, feedback_enable_in = 1'b0;
    logic        step_in = 1'b0, dir_in = 1'b0, enc_a, enc_b, enc_n, rd_pend = 1'b0;
    logic        goal_step_out, goal_down_out, deviation_irq_out;
    logic [4:0]  motion_flags_out;
    logic [31:0] exp_q[$];
    int          err_count = 0, check_count = 0, step_cnt = 0, irq_cnt = 0;
    // ==========================================================
    // Clock, design and encoder
    initial forever #25 clock_in = ~clock_in;
    encoder_feedback_status encoder_feedback_status_inst (.clock_in(clock_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .enc_a_in(enc_a),
        .enc_b_in(enc_b), .enc_n_in(enc_n), .step_in(step_in), .dir_in(dir_in),
        .x_actual_in(x_actual_in), .x_target_in(x_target_in), .v_actual_in(v_actual_in),
        .v_target_in(v_target_in), .v_max_in(v_max_in), .positioning_in(positioning_in),
        .soft_limit_stop_in(soft_limit_stop_in), .ref_switch_event_in(ref_switch_event_in),
        .virtual_stop_event_in(virtual_stop_event_in), .step_enable_in(step_enable_in),
        .feedback_enable_in(feedback_enable_in), .goal_step_out(goal_step_out),
        .goal_down_out(goal_down_out), .motion_flags_out(motion_flags_out),
        .deviation_irq_out(deviation_irq_out));
    quad_encoder_model quad_encoder_model_inst (.clock_in(clock_in), .enc_a_out(enc_a),
        .enc_b_out(enc_b), .enc_n_out(enc_n));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clock_in);
        #2;
    endtask
    // Write and read hold the strobe for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        at(1);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        at(1);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        at(1);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        exp_q.push_back(exp);
        at(1);
        reg_rd_in = 1'b0;
    endtask
    task automatic steps(input int n);
        repeat (n) begin
            at(1);
            step_in = 1'b1;
            at(4);
            step_in = 1'b0;
            at(4);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // Monitors: read data is valid the cycle after the strobe
    always @(posedge clock_in) rd_pend <= reg_rd_in;
    always @(negedge clock_in) begin
        if (rd_pend === 1'b1) check(reg_rdata_out, exp_q.pop_front());
    end
    always @(posedge clock_in) begin
        if (goal_step_out === 1'b1) step_cnt++;
        if (deviation_irq_out === 1'b1) irq_cnt++;
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #1ms;
        err_count++;
        give_verdict();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(41));
        at(3);
        rst_in = 1'b0;
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h7);
        rd(efs_pkg::ADDR_ENC_INCREMENT, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset done");
        quad_encoder_model_inst.turn(4, 1'b1, 4);
        at(6);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'h4);
        quad_encoder_model_inst.turn(1, 1'b0, 12);
        at(6);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'h3);
        // Edge-triggered index with clear; event only on the rising edge into the active-high level
        wr(efs_pkg::ADDR_ENC_CONFIG, 32'h144);
        quad_encoder_model_inst.pulse_index(6);
        at(8);
        rd(efs_pkg::ADDR_INDEX_FLAG, 32'h1);
        rd(efs_pkg::ADDR_INDEX_FLAG, 32'h0);
        rd(efs_pkg::ADDR_INDEX_CAPTURE, 32'h3);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'h0);
        wr(efs_pkg::ADDR_INDEX_CAPTURE, 32'h5);
        rd(efs_pkg::ADDR_INDEX_CAPTURE, 32'h3);
        $display("test index done");
        wr(efs_pkg::ADDR_ENC_INCREMENT, 32'hFFFF_0000);
        quad_encoder_model_inst.turn(3, 1'b1, 4);
        at(6);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'hFFFF_FFFD);
        wr(efs_pkg::ADDR_ENC_POSITION, 32'h0);
        wr(efs_pkg::ADDR_ENC_CONFIG, 32'h2000);
        wr(efs_pkg::ADDR_ENC_INCREMENT, 32'h0000_1388);
        quad_encoder_model_inst.turn(4, 1'b1, 4);
        at(6);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'h2);
        wr(efs_pkg::ADDR_ENC_POSITION, 32'h0);
        wr(efs_pkg::ADDR_ENC_CONFIG, 32'h0);
        quad_encoder_model_inst.turn(14, 1'b1, 4);
        at(6);
        rd(efs_pkg::ADDR_ENC_POSITION, 32'h1);
        $display("test scaling done");
        for (int i = 0; i < 2; i++) begin
            r = $urandom();
            x_actual_in = r;
            ref_switch_event_in = (i == 0);
            virtual_stop_event_in = (i == 1);
            at(1);
            {ref_switch_event_in, virtual_stop_event_in} = 2'b00;
            x_actual_in = ~r;
            rd(efs_pkg::ADDR_SWITCH_CAPTURE, r);
        end
        $display("test switch capture done");
        // Deviation around encoder position 1, threshold 0x100
        // Threshold and inputs settle before the loop runs, so no early warning pulse
        wr(efs_pkg::ADDR_DEV_THRESHOLD, 32'h100);
        {v_actual_in, v_target_in, x_target_in, x_actual_in} = {32'h5, 32'h5, 32'h0, 32'h101};
        feedback_enable_in = 1'b1;
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h02);
        x_actual_in = 32'h102;
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h12);
        {x_actual_in, positioning_in, v_target_in} = {32'hFFFF_FF00, 1'b1, 32'h3};
        v_max_in = 32'h5;
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h12);
        feedback_enable_in = 1'b0;
        x_actual_in = 32'h1;
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h12);
        // Stopped off target by a soft limit, then with the limit stop gone
        {v_actual_in, soft_limit_stop_in} = {32'h0, 1'b1};
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h15);
        soft_limit_stop_in = 1'b0;
        at(4);
        rd(efs_pkg::ADDR_MOTION_FLAGS, 32'h14);
        check(32'(irq_cnt), 32'h1);
        $display("test deviation done");
        step_enable_in = 1'b1;
        dir_in = 1'b1;
        wr(efs_pkg::ADDR_STEP_SCALE, 32'h7FFF);
        steps(3);
        at(4);
        check(32'(step_cnt), 32'h3);
        check({31'h0, goal_down_out}, 32'h0);
        wr(efs_pkg::ADDR_STEP_SCALE, 32'hBFFF);
        steps(4);
        at(4);
        check(32'(step_cnt), 32'h5);
        check({31'h0, goal_down_out}, 32'h1);
        step_enable_in = 1'b0;
        steps(2);
        at(4);
        check(32'(step_cnt), 32'h5);
        $display("test step input done");
        give_verdict();
    end
endmodule // encoder_feedback_status_bench
